// ==== core/vri2c_pkg.sv ====
// Purpose: shared constants for the voice recorder serial port ends
// Assumes: 100 MHz system clock on the host end
// Notes: slave address value is arbitrary, set per board
`default_nettype none
package vri2c_pkg;
	localparam int VR_BYTE_BITS = 8;
	// arbitrary neutral slave address
	localparam logic [6:0] VR_SLV_ADDR = 7'h2A;
	localparam logic VR_DIR_WR = 1'b0;
	localparam logic VR_DIR_RD = 1'b1;
	localparam int VR_MEM_AW = 8;
	localparam int VR_MEM_DEPTH = 256;
	localparam int VR_CLK_MHZ = 100;
	// one quarter of a bus clock period, in ns
	localparam int VR_SCL_QTR_NS = 250;
	localparam int VR_QTR_CYC = (VR_SCL_QTR_NS * VR_CLK_MHZ + 999) / 1000;
	localparam int VR_TICK_W = 5;
	localparam logic [VR_TICK_W-1:0] VR_QTR_LAST = VR_TICK_W'(VR_QTR_CYC - 1);
	localparam logic [3:0] VR_ACK_BIT = 4'h8;
	localparam logic [2:0] VR_LAST_BIT = 3'h7;
	localparam logic [1:0] VR_IDX_CMD = 2'h0;
	localparam logic [1:0] VR_IDX_AHI = 2'h1;
	localparam logic [1:0] VR_IDX_ALO = 2'h2;
	localparam logic [1:0] VR_IDX_END = 2'h3;
endpackage
`default_nettype wire

// ==== core/vri2c_bus_if.sv ====
// Purpose: two-wire bus between host end and device end
// Assumes: both lines pulled up; a line is low while any enable pulls it
// Notes: no clock stretching, so only the host drives the clock line
`timescale 1ns/100ps
`default_nettype none
interface vri2c_bus_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	// wired-and of the pull-up and every enabled driver
	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
	modport host (
		output host_scl_o,
		output host_scl_oe,
		output host_sda_o,
		output host_sda_oe,
		input scl,
		input sda
	);
	modport dev (
		output dev_sda_o,
		output dev_sda_oe,
		input scl,
		input sda
	);
endinterface
`default_nettype wire

// ==== core/vri2c_host.sv ====
// Purpose: bus master that runs command writes, status and array reads
// Assumes: clk at 100 MHz; bus clock made by a quarter-period divider
// Notes: one request at a time; req is taken only while ready is high
`timescale 1ns/100ps
`default_nettype none
module vri2c_host
	import vri2c_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	vri2c_bus_if.host bus,
	input wire logic req,
	input wire logic [1:0] wr_n,
	input wire logic [7:0] wr_cmd,
	input wire logic [15:0] wr_addr,
	input wire logic [7:0] rd_n,
	output logic ready,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic done,
	output logic nack_err
);
	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} vri2c_hst_t;
	typedef enum logic [1:0] {K_ADDR, K_WR, K_RD} vri2c_kind_t;
	vri2c_hst_t st_q, st_d;
	vri2c_kind_t kind_q, kind_d;
	logic [VR_TICK_W-1:0] tick_q, tick_d;
	logic [1:0] ph_q, ph_d, wrn_q, wrn_d, wri_q, wri_d;
	logic [3:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d, left_q, left_d, cmd_q, cmd_d, rdat_q, rdat_d;
	logic [15:0] adr_q, adr_d;
	logic rw_q, rw_d, ack_q, ack_d, scl_q, scl_d, sda_q, sda_d;
	logic rv_q, rv_d, done_q, done_d, err_q, err_d, s1_q, s2_q;
	logic qtick;
	logic [7:0] wbyte;

	// quarter-period strobe; every bus edge lands on one
	assign qtick = (st_q != H_IDLE) && (tick_q == VR_QTR_LAST);
	assign wbyte = (wri_q == VR_IDX_CMD) ? cmd_q :
		(wri_q == VR_IDX_AHI) ? adr_q[15:8] : adr_q[7:0];

	always_comb begin
		st_d = st_q;
		kind_d = kind_q;
		tick_d = (qtick || st_q == H_IDLE) ? '0 : tick_q + 1'b1;
		ph_d = qtick ? ph_q + 2'h1 : ph_q;
		wrn_d = wrn_q;
		wri_d = wri_q;
		bit_d = bit_q;
		sh_d = sh_q;
		left_d = left_q;
		cmd_d = cmd_q;
		adr_d = adr_q;
		rw_d = rw_q;
		ack_d = ack_q;
		scl_d = scl_q;
		sda_d = sda_q;
		rdat_d = rdat_q;
		rv_d = 1'b0;
		done_d = 1'b0;
		err_d = err_q;
		case (st_q)
			H_IDLE: begin
				scl_d = 1'b0; // both lines released while idle
				sda_d = 1'b0;
				if (req) begin // only from idle or after a stop
					st_d = H_START;
					ph_d = 2'h2; // fresh start skips the two line release steps
					wrn_d = wr_n;
					wri_d = VR_IDX_CMD;
					cmd_d = wr_cmd;
					adr_d = wr_addr;
					left_d = rd_n;
					// a probe with nothing to read stays a write
					rw_d = (wr_n == 2'h0 && rd_n != 8'h00) ? VR_DIR_RD :
						VR_DIR_WR;
					err_d = 1'b0;
				end
			end
			H_START: if (qtick) begin
				case (ph_q)
					2'h0: sda_d = 1'b0;
					2'h1: scl_d = 1'b0;
					2'h2: sda_d = 1'b1; // data falls, clock high
					default: begin
						scl_d = 1'b1;
						st_d = H_BIT;
						kind_d = K_ADDR;
						bit_d = 4'h0;
						sh_d = {VR_SLV_ADDR, rw_q}; // address byte first
					end
				endcase
			end
			H_BIT: if (qtick) begin
				case (ph_q)
					2'h0: begin // data changes only with clock low
						if (bit_q != VR_ACK_BIT)
							sda_d = (kind_q != K_RD) && !sh_q[7];
						else // ack all read bytes but the last
							sda_d = (kind_q == K_RD) && (left_q != 8'h01);
					end
					2'h1: scl_d = 1'b0;
					2'h2: begin
						if (bit_q != VR_ACK_BIT)
							sh_d = {sh_q[6:0], s2_q};
						else
							ack_d = s2_q; // low means acknowledged
					end
					default: begin
						scl_d = 1'b1;
						bit_d = bit_q + 4'h1; // eight bits then ack slot
						if (bit_q == VR_ACK_BIT) begin
							bit_d = 4'h0;
							ph_d = 2'h0;
							if (kind_q == K_RD) begin
								rv_d = 1'b1;
								rdat_d = sh_q;
								left_d = left_q - 8'h01;
								if (left_q == 8'h01)
									st_d = H_STOP;
							end else if (ack_q) begin
								err_d = 1'b1;
								st_d = H_STOP;
							end else if (kind_q == K_ADDR && rw_q) begin
								kind_d = K_RD;
							end else if (wri_q < wrn_q) begin
								kind_d = K_WR; // at most three write bytes per frame
								sh_d = wbyte;
								wri_d = wri_q + 2'h1;
							end else if (left_q != 8'h00) begin
								rw_d = VR_DIR_RD; // turn round for array read
								st_d = H_START;
							end else begin
								st_d = H_STOP;
							end
						end
					end
				endcase
			end
			H_STOP: if (qtick) begin
				case (ph_q)
					2'h0: sda_d = 1'b1;
					2'h1: scl_d = 1'b0;
					2'h2: sda_d = 1'b0; // data rises, clock high
					default: begin
						st_d = H_IDLE;
						done_d = 1'b1;
					end
				endcase
			end
			default: st_d = H_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		s1_q <= bus.sda; // bus level is asynchronous to clk
		s2_q <= s1_q;
		if (rst) begin
			st_q <= H_IDLE;
			kind_q <= K_ADDR;
			tick_q <= '0;
			ph_q <= 2'h0;
			wrn_q <= 2'h0;
			wri_q <= 2'h0;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			left_q <= 8'h00;
			cmd_q <= 8'h00;
			adr_q <= 16'h0000;
			rw_q <= 1'b0;
			ack_q <= 1'b1;
			scl_q <= 1'b0;
			sda_q <= 1'b0;
			rdat_q <= 8'h00;
			rv_q <= 1'b0;
			done_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			st_q <= st_d;
			kind_q <= kind_d;
			tick_q <= tick_d;
			ph_q <= ph_d;
			wrn_q <= wrn_d;
			wri_q <= wri_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			left_q <= left_d;
			cmd_q <= cmd_d;
			adr_q <= adr_d;
			rw_q <= rw_d;
			ack_q <= ack_d;
			scl_q <= scl_d;
			sda_q <= sda_d;
			rdat_q <= rdat_d;
			rv_q <= rv_d;
			done_q <= done_d;
			err_q <= err_d;
		end
	end

	// open-drain pins: output stays low, enable pulls the line
	assign bus.host_scl_o = 1'b0;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_scl_oe = scl_q;
	assign bus.host_sda_oe = sda_q;
	assign ready = (st_q == H_IDLE);
	assign rd_data = rdat_q;
	assign rd_valid = rv_q;
	assign done = done_q;
	assign nack_err = err_q;
endmodule
`default_nettype wire

// ==== core/vri2c_dev.sv ====
// Purpose: slave end of the recorder serial port, clocked by the bus clock
// Assumes: status is quasi-static; array writes avoid the byte being read
// Notes: link flops reset asynchronously since the bus clock may stand still
// Function
// - both lines released high while bus idle
// - data falling with clock high starts frame
// - data rising with clock high ends frame; after a write frame, state D_WR and frame_busy hold until the next start
// - no limit on bytes within one frame
// - eight bits then one acknowledge slot
// - addressed receiver acknowledges every received byte
// - master acknowledges every read byte but last
// - acknowledge holds data low through clock high
// - after master refusal transmitter releases data line
// - seven address bits plus direction, compared locally
// - first byte after start is the address
// - direction zero means master sends all data
// - read without command returns status bytes
// - master refusal ends status byte output
// - command, two address bytes, then turn to read
// - array bytes flow while master keeps clocking
// - master refusal ends array byte output
// - data changes only while clock is low
// - master starts only when the bus is free
`timescale 1ns/100ps
`default_nettype none
module vri2c_dev
	import vri2c_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	vri2c_bus_if.dev bus,
	input wire logic mem_we,
	input wire logic [VR_MEM_AW-1:0] mem_waddr,
	input wire logic [7:0] mem_wdata,
	input wire logic [15:0] status,
	output logic cmd_valid,
	output logic [7:0] cmd,
	output logic frame_busy
);
	typedef enum logic [2:0] {
		D_IDLE,
		D_ADDR,
		D_WR,
		D_ACK_DEV,
		D_RD,
		D_ACK_HOST
	} vri2c_dst_t;

	logic [7:0] mem_q [VR_MEM_DEPTH];
	logic start_tog_q, start_tog_d, stop_tog_q, stop_tog_d;
	logic start_seen_q, start_seen_d, stop_seen_q, stop_seen_d;
	logic start_pend, stop_pend;
	vri2c_dst_t st_q, st_d;
	logic [2:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d, tx_q, tx_d, cmdr_q, cmdr_d;
	logic [1:0] idx_q, idx_d;
	logic [15:0] adr_q, adr_d;
	logic rw_q, rw_d, cmds_q, cmds_d, sidx_q, sidx_d, tog_q, tog_d;
	logic drv_q, drv_d;
	logic [7:0] byte_w;
	logic cs1_q, cs2_q, cs3_q, cv_q, cv_d;
	logic [7:0] cmdo_q, cmdo_d;
	logic busy1_q, busy2_q;

	// array filled from the system side, read on the bus side
	always_ff @(posedge clk) begin
		if (mem_we)
			mem_q[mem_waddr] <= mem_wdata;
	end

	// frame markers: data edges while the clock is high
	always_comb begin
		start_tog_d = bus.scl ? ~start_tog_q : start_tog_q;
		stop_tog_d = bus.scl ? ~stop_tog_q : stop_tog_q;
	end

	always_ff @(negedge bus.sda or posedge rst) begin
		if (rst)
			start_tog_q <= 1'b0;
		else
			start_tog_q <= start_tog_d;
	end

	always_ff @(posedge bus.sda or posedge rst) begin
		if (rst)
			stop_tog_q <= 1'b0;
		else
			stop_tog_q <= stop_tog_d;
	end

	// a toggle not yet seen by the clock side is a pending marker
	assign start_pend = start_tog_q ^ start_seen_q;
	assign stop_pend = stop_tog_q ^ stop_seen_q;
	assign byte_w = {sh_q[6:0], bus.sda};

	// bit engine; samples data on each rising bus clock edge
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		tx_d = tx_q;
		cmdr_d = cmdr_q;
		idx_d = idx_q;
		adr_d = adr_q;
		rw_d = rw_q;
		cmds_d = cmds_q;
		sidx_d = sidx_q;
		tog_d = tog_q;
		start_seen_d = start_tog_q;
		stop_seen_d = stop_tog_q;
		if (start_pend) begin
			// this edge already carries the first address bit
			st_d = D_ADDR;
			cnt_d = 3'h1;
			sh_d = {7'h00, bus.sda};
			idx_d = VR_IDX_CMD;
			sidx_d = 1'b0;
			if (stop_pend)
				cmds_d = 1'b0; // fresh frame, repeated start keeps it
		end else begin
			case (st_q)
				D_ADDR: begin
					sh_d = byte_w;
					cnt_d = cnt_q + 3'h1;
					if (cnt_q == VR_LAST_BIT) begin
						if (byte_w[7:1] == VR_SLV_ADDR) begin
							rw_d = byte_w[0];
							st_d = D_ACK_DEV;
						end else begin
							st_d = D_IDLE; // not ours, stay silent
						end
					end
				end
				D_WR: begin
					sh_d = byte_w; // every bit from the master
					cnt_d = cnt_q + 3'h1;
					if (cnt_q == VR_LAST_BIT) begin
						st_d = D_ACK_DEV;
						case (idx_q)
							VR_IDX_CMD: begin
								cmdr_d = byte_w;
								cmds_d = 1'b1;
								tog_d = ~tog_q;
							end
							VR_IDX_AHI: adr_d[15:8] = byte_w;
							VR_IDX_ALO: adr_d[7:0] = byte_w;
							default: cmdr_d = cmdr_q;
						endcase
						if (idx_q != VR_IDX_END)
							idx_d = idx_q + 2'h1; // further bytes acked only
					end
				end
				D_ACK_DEV: begin
					cnt_d = 3'h0;
					if (rw_q == VR_DIR_RD) begin
						st_d = D_RD;
						if (cmds_q) begin
							tx_d = mem_q[adr_q[VR_MEM_AW-1:0]];
							adr_d = adr_q + 16'h0001;
						end else begin
							tx_d = status[15:8];
							sidx_d = 1'b1;
						end
					end else begin
						st_d = D_WR;
					end
				end
				D_RD: begin
					cnt_d = cnt_q + 3'h1;
					if (cnt_q == VR_LAST_BIT)
						st_d = D_ACK_HOST;
				end
				D_ACK_HOST: begin
					cnt_d = 3'h0;
					if (bus.sda) begin
						st_d = D_IDLE; // refusal ends output
					end else begin
						st_d = D_RD; // keep going as long as clocked
						if (cmds_q) begin
							tx_d = mem_q[adr_q[VR_MEM_AW-1:0]];
							adr_d = adr_q + 16'h0001;
						end else begin
							tx_d = sidx_q ? status[7:0] : status[15:8];
							sidx_d = ~sidx_q;
						end
					end
				end
				default: st_d = D_IDLE;
			endcase
		end
	end

	always_ff @(posedge bus.scl or posedge rst) begin
		if (rst) begin
			st_q <= D_IDLE;
			cnt_q <= 3'h0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			cmdr_q <= 8'h00;
			idx_q <= 2'h0;
			adr_q <= 16'h0000;
			rw_q <= 1'b0;
			cmds_q <= 1'b0;
			sidx_q <= 1'b0;
			tog_q <= 1'b0;
			start_seen_q <= 1'b0;
			stop_seen_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			cmdr_q <= cmdr_d;
			idx_q <= idx_d;
			adr_q <= adr_d;
			rw_q <= rw_d;
			cmds_q <= cmds_d;
			sidx_q <= sidx_d;
			tog_q <= tog_d;
			start_seen_q <= start_seen_d;
			stop_seen_q <= stop_seen_d;
		end
	end

	// line drive changes on the falling clock edge only
	always_comb begin
		case (st_q)
			D_ACK_DEV: drv_d = 1'b1; // ack every byte received
			D_RD: drv_d = ~tx_q[VR_LAST_BIT - cnt_q];
			default: drv_d = 1'b0; // released in ack slot of a read
		endcase
	end

	always_ff @(negedge bus.scl or posedge rst) begin
		if (rst)
			drv_q <= 1'b0;
		else
			drv_q <= drv_d;
	end

	// a stop releases at once, since no clock edge may follow it
	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe = drv_q & ~stop_pend;

	// command byte handed to clk by toggle; the byte is long stable by then
	always_comb begin
		cv_d = cs2_q ^ cs3_q;
		cmdo_d = cv_d ? cmdr_q : cmdo_q;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cs1_q <= 1'b0;
			cs2_q <= 1'b0;
			cs3_q <= 1'b0;
			cv_q <= 1'b0;
			cmdo_q <= 8'h00;
			busy1_q <= 1'b0;
			busy2_q <= 1'b0;
		end else begin
			cs1_q <= tog_q;
			cs2_q <= cs1_q;
			cs3_q <= cs2_q;
			cv_q <= cv_d;
			cmdo_q <= cmdo_d;
			busy1_q <= (st_q != D_IDLE);
			busy2_q <= busy1_q;
		end
	end

	assign cmd_valid = cv_q;
	assign cmd = cmdo_q;
	assign frame_busy = busy2_q;
endmodule
`default_nettype wire

// ==== tb/vri2c_sva.sv ====
// Purpose: protocol checks on the two-wire bus between host and device
// Assumes: lines sampled on the 100 MHz clock, far faster than the bus
// Notes: bit and byte position are rebuilt here from the resolved lines
`timescale 1ns/100ps
`default_nettype none
module vri2c_sva
	import vri2c_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe
);
	logic scl_q, sda_q, hit_q, hit_d, dir_q, dir_d;
	logic [3:0] bit_q, bit_d;
	logic [1:0] byte_q, byte_d;
	logic [7:0] sh_q, sh_d;
	logic rise, start, stop, ack;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// line events as seen from the system clock
	assign rise = scl && !scl_q;
	assign start = scl && scl_q && !sda && sda_q;
	assign stop = scl && scl_q && sda && !sda_q;
	assign ack = rise && bit_q == VR_ACK_BIT;
	// slot count and address capture since the last start
	always_comb begin
		bit_d = bit_q;
		byte_d = byte_q;
		sh_d = sh_q;
		hit_d = hit_q;
		dir_d = dir_q;
		if (start || stop) begin
			bit_d = 4'h0;
			byte_d = 2'h0;
			hit_d = 1'b0;
		end else if (rise) begin
			bit_d = ack ? 4'h0 : bit_q + 4'h1;
			if (!ack) sh_d = {sh_q[6:0], sda};
			if (ack && byte_q != 2'h3) byte_d = byte_q + 2'h1;
			if (ack && byte_q == 2'h0) begin
				hit_d = sh_q[7:1] == VR_SLV_ADDR;
				dir_d = sh_q[0];
			end
		end
	end
	// registers only; idle lines read as high after reset
	always_ff @(posedge clk) begin
		if (rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			bit_q <= 4'h0;
			byte_q <= 2'h0;
			sh_q <= 8'h00;
			hit_q <= 1'b0;
			dir_q <= 1'b0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			bit_q <= bit_d;
			byte_q <= byte_d;
			sh_q <= sh_d;
			hit_q <= hit_d;
			dir_q <= dir_d;
		end
	end
	sequence s_idle;
		(sda && scl) [*8];
	endsequence
	sequence s_quiet;
		!dev_sda_oe [*8];
	endsequence
	a_stop_idle: assert property (stop |=> s_idle)
		else $error("bus not idle after stop");
	// the clock rise that precedes a stop leaves slot one open
	a_nine_slots: assert property (stop |-> bit_q == 4'h1)
		else $error("stop not on a byte boundary");
	a_addr_ack: assert property (ack && byte_q == 2'h0 |->
		dev_sda_oe == (sh_q[7:1] == VR_SLV_ADDR))
		else $error("address acknowledge wrong");
	a_write_ack: assert property (ack && byte_q != 2'h0 && hit_q &&
		!dir_q |-> dev_sda_oe)
		else $error("write byte not acknowledged");
	// the ack slot is left out: there the device must pull the line
	a_write_quiet: assert property (scl && hit_q && !dir_q &&
		byte_q != 2'h0 && bit_q != 4'h0 && bit_q != VR_ACK_BIT |->
		!dev_sda_oe)
		else $error("device drives during write data");
	a_nack_release: assert property (
		ack && byte_q != 2'h0 && hit_q && dir_q && sda |=> s_quiet)
		else $error("device drives after refusal");
	// the ack slot is left out: there the host may acknowledge
	a_host_release: assert property (scl && hit_q && dir_q &&
		byte_q != 2'h0 && bit_q > 4'h1 && bit_q != VR_ACK_BIT |->
		!host_sda_oe)
		else $error("host drives during read data");
	a_dev_hold_high: assert property (dev_sda_oe && scl |=>
		dev_sda_oe || !scl)
		else $error("device data moved while clock high");
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: self-checking bench joining host end and device end
// Assumes: bus clock comes from the host divider, not from the bench
// Notes: driver queues expected bytes, a watcher matches them in order
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin \
	comparisons++; \
	if ((a) !== (e)) begin \
		failures++; \
		$display("CHECK FAILED %s exp %h seen %h", n, e, a); \
	end \
end
module testbench
	import vri2c_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b0;
	logic req = 1'b0;
	logic [1:0] wr_n = 2'h0;
	logic [7:0] wr_cmd = 8'h00;
	logic [15:0] wr_addr = 16'h0000;
	logic [7:0] rd_n = 8'h00;
	logic mem_we = 1'b0;
	logic [7:0] mem_waddr = 8'h00;
	logic [7:0] mem_wdata = 8'h00;
	logic [15:0] status = 16'h0000;
	logic ready, rd_valid, done, nack_err, cmd_valid, frame_busy;
	logic [7:0] rd_data, cmd, exp_b, base;
	logic [7:0] mem [256];
	logic [7:0] rdq [$];
	logic [7:0] cmdq [$];
	logic [31:0] seed = 32'h00016F8B;
	int failures = 0;
	int comparisons = 0;
	int n;
	always #5 clk = ~clk;
	vri2c_bus_if bus ();
	vri2c_host i_vri2c_host (.clk(clk), .rst(rst), .bus(bus.host),
		.req(req), .wr_n(wr_n), .wr_cmd(wr_cmd), .wr_addr(wr_addr),
		.rd_n(rd_n), .ready(ready), .rd_data(rd_data),
		.rd_valid(rd_valid), .done(done), .nack_err(nack_err));
	vri2c_dev i_vri2c_dev (.clk(clk), .rst(rst), .bus(bus.dev),
		.mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
		.status(status), .cmd_valid(cmd_valid), .cmd(cmd),
		.frame_busy(frame_busy));
	vri2c_sva i_vri2c_sva (.clk(clk), .rst(rst), .scl(bus.scl),
		.sda(bus.sda), .host_sda_oe(bus.host_sda_oe),
		.dev_sda_oe(bus.dev_sda_oe));
	// seed 94091; a shift register keeps the run repeatable
	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction
	task automatic summarize();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// one request held until taken, then a bounded wait for done
	task automatic xfer(input logic [1:0] wn, input logic [7:0] rn);
		int i;
		wr_n = wn;
		rd_n = rn;
		req = 1'b1;
		for (i = 0; i < 100 && ready !== 1'b1; i++) @(negedge clk);
		if (i == 100) begin
			failures++;
			summarize();
		end
		@(negedge clk);
		req = 1'b0;
		for (i = 0; i < 20000 && done !== 1'b1; i++) @(negedge clk);
		if (i == 20000) begin
			failures++;
			summarize();
		end
		`CHK("nack_err", 1'b0, nack_err)
	endtask
	// watcher: every result takes the oldest note off its queue
	// sampled mid-cycle, where the pulses and data have settled
	always @(negedge clk) begin
		if (rd_valid === 1'b1) begin
			`CHK("rd_note", 1'b1, rdq.size() > 0)
			exp_b = (rdq.size() > 0) ? rdq.pop_front() : 8'h00;
			`CHK("rd_data", exp_b, rd_data)
		end
		if (cmd_valid === 1'b1) begin
			`CHK("cmd_note", 1'b1, cmdq.size() > 0)
			exp_b = (cmdq.size() > 0) ? cmdq.pop_front() : 8'h00;
			`CHK("cmd", exp_b, cmd)
		end
	end
	initial begin
		// a real rising edge, so the link-side flops take the async reset
		#1 rst = 1'b1;
		status = {rnd(), rnd()};
		repeat (8) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		// array bytes across the top of the array, so reads wrap
		base = 8'hFC;
		for (n = 0; n < 8; n++) begin
			mem_we = 1'b1;
			mem_waddr = base + 8'(n);
			mem_wdata = rnd();
			mem[mem_waddr] = mem_wdata;
			@(negedge clk);
		end
		mem_we = 1'b0;
		xfer(2'h0, 8'h00);
		$display("test address probe finished");
		for (n = 0; n < 3; n++) rdq.push_back(n[0] ? status[7:0] : status[15:8]);
		xfer(2'h0, 8'h03);
		`CHK("frame_busy", 1'b0, frame_busy)
		$display("test status read finished");
		// every command length, random command and address bytes
		for (n = 1; n < 4; n++) begin
			wr_cmd = rnd();
			wr_addr = {rnd(), rnd()};
			cmdq.push_back(wr_cmd);
			xfer(2'(n), 8'h00);
		end
		$display("test command writes finished");
		// a long read that wraps, then a single byte read
		wr_cmd = rnd();
		wr_addr = {rnd(), base};
		cmdq.push_back(wr_cmd);
		for (n = 0; n < 7; n++) rdq.push_back(mem[base + 8'(n)]);
		xfer(2'h3, 8'h07);
		wr_addr = {rnd(), base + 8'h07};
		cmdq.push_back(wr_cmd);
		rdq.push_back(mem[base + 8'h07]);
		xfer(2'h3, 8'h01);
		$display("test array reads finished");
		repeat (20) @(negedge clk);
		`CHK("frame_busy", 1'b0, frame_busy)
		`CHK("rd_left", 0, rdq.size())
		`CHK("cmd_left", 0, cmdq.size())
		summarize();
	end
endmodule
`default_nettype wire
